// *** ssrc_top.sv ***
// Speed setpoint source: emulated potentiometer and fixed setpoints
`timescale 1ns/1ps

// Overview of operation
// [RULE_01] Switch-on loads start value or stored value
// [RULE_02] Automatic mode: bit 01 selects ramp or jump
// [RULE_03] Manual mode always ramps
// [RULE_04] Bit 02 adds initial rounding to ramp
// [RULE_05] Bits 03 and 00 keep value nonvolatile
// [RULE_06] Bit 04 ramps while motor is off
// [RULE_07] Configuration resets to 00110 binary
// [RULE_08] Output never above maximum speed
// [RULE_09] Output never below minimum speed; the code lets the maximum win when the minimum exceeds it
// [RULE_10] Accept rising edge loads setting value
// [RULE_11] Direct mode sums enabled four setpoints
// [RULE_12] Binary mode picks one of sixteen
// [RULE_13] Raise ramps up, lower ramps down
// [RULE_14] Ramp times configurable, ten seconds default
// [RULE_15] Start value configurable, zero default
// [RULE_16] Raise with lower holds the output
// [RULE_17] Clamp applies after every load or step
module ssrc_top #(
	parameter int TICK_CYC = ssrc_pkg::TICK_CYCLES // Cycles per ms tick
) (
	input wire logic CORE_CLK_I, // Core clock, 200 MHz
	input wire logic RSTN_I, // Synchronous reset, active low
	input wire logic [7:0] AVS_ADDRESS_I, // Byte address
	input wire logic AVS_READ_I, // Read request
	input wire logic AVS_WRITE_I, // Write request
	input wire logic [31:0] AVS_WRITEDATA_I, // Write data
	input wire logic [3:0] AVS_BYTEENABLE_I, // Byte lanes
	output logic [31:0] AVS_READDATA_O, // Read data
	output logic AVS_WAITREQUEST_O, // Stall
	input wire logic MOTOR_ON_I, // Motor switched on
	input wire logic POT_RAISE_COMMAND_I, // Raise command
	input wire logic POT_LOWER_COMMAND_I, // Lower command
	input wire logic AUTO_MODE_SELECT_I, // High for automatic mode
	input wire logic ACCEPT_SETTING_STROBE_I, // Accept setting value
	input wire logic [ssrc_pkg::SPD_W-1:0] SETTING_VALUE_SOURCE_I, // rpm
	input wire logic [3:0] FIXED_SELECT_I, // Fixed selection bits
	input wire logic NV_VALID_I, // Stored value present
	input wire logic [ssrc_pkg::SPD_W-1:0] NV_DATA_I, // Stored value
	output logic NV_WRITE_O, // Store strobe
	output logic [ssrc_pkg::SPD_W-1:0] NV_DATA_O, // Value to store
	output logic [ssrc_pkg::SPD_W-1:0] POT_OUTPUT_O, // Pot setpoint rpm
	output logic [ssrc_pkg::SPD_W-1:0] FIXED_SETPOINT_O, // Fixed rpm
	output logic FIXED_ACTIVE_O // Some fixed setpoint selected
);
	import ssrc_pkg::*;

	// Limit a wide signed value to a window, the upper bound winning
	function automatic logic [SPD_W-1:0] spd_clamp(
		input logic signed [SUM_W-1:0] v,
		input logic signed [SUM_W-1:0] lo,
		input logic signed [SUM_W-1:0] hi);
		logic signed [SUM_W-1:0] r;
		r = v;
		if (r < lo) begin
			r = lo;
		end
		if (r > hi) begin
			r = hi;
		end
		return r[SPD_W-1:0];
	endfunction : spd_clamp

	// Sign-extend a speed to the wide arithmetic width
	function automatic logic signed [SUM_W-1:0] spd_wide(
		input logic [SPD_W-1:0] v);
		return {{(SUM_W-SPD_W){v[SPD_W-1]}}, v};
	endfunction : spd_wide

	// Merge the two low byte lanes of a write into a 16-bit register
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction : lane_merge

	ssrc_mem_if tbl ();

	ssrc_fixed_mem u_mem (
		.clk_i (CORE_CLK_I),
		.rstn_i (RSTN_I),
		.mem (tbl.mem)
	);

	logic [CFG_W-1:0] cfg_q;
	logic [15:0] max_q, min_q, start_q, rup_q, rdn_q;
	ssrc_fix_mode_e fmode_q;
	ssrc_bus_e bus_q;
	logic [31:0] rdata_q;
	logic wr_go, bus_mem, is_table;
	logic [5:0] word_ofs;

	// Register bus: every access stalls at least one cycle
	assign is_table = AVS_ADDRESS_I[7:6] == TABLE_PAGE;
	assign word_ofs = AVS_ADDRESS_I[7:2];
	assign AVS_WAITREQUEST_O = bus_q != BUS_DONE;
	assign AVS_READDATA_O = rdata_q;
	assign wr_go = AVS_WRITE_I && bus_q == BUS_DONE;
	assign bus_mem = AVS_READ_I && is_table && bus_q == BUS_IDLE;

	logic [SPD_W-1:0] pot_q, fix_q;
	logic motor_q, ramping;

	// Read mux for plain registers; unmapped words read as zero
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		case (a)
			OFS_CONFIG: r[CFG_W-1:0] = cfg_q;
			OFS_MAX_SPEED: r[15:0] = max_q;
			OFS_MIN_SPEED: r[15:0] = min_q;
			OFS_START_VALUE: r[15:0] = start_q;
			OFS_RAMP_UP: r[15:0] = rup_q;
			OFS_RAMP_DOWN: r[15:0] = rdn_q;
			OFS_FIX_MODE: r[1:0] = fmode_q;
			OFS_POT_OUT: r[15:0] = pot_q;
			OFS_FIX_OUT: r[15:0] = fix_q;
			OFS_STATUS: begin
				r[ST_MOTOR_ON] = motor_q;
				r[ST_FIX_ACTIVE] = FIXED_ACTIVE_O;
				r[ST_RAMPING] = ramping;
			end
			default: r = '0;
		endcase
		return r;
	endfunction : reg_read

	// Answer sequence; table reads wait one extra cycle for the memory
	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			bus_q <= BUS_IDLE;
			rdata_q <= '0;
		end else begin
			case (bus_q)
				BUS_IDLE: begin
					if (bus_mem) begin
						bus_q <= BUS_MEM;
					end else if (AVS_READ_I || AVS_WRITE_I) begin
						bus_q <= BUS_DONE;
						rdata_q <= is_table ? '0 : reg_read(AVS_ADDRESS_I);
					end
				end
				BUS_MEM: begin
					bus_q <= BUS_DONE;
					rdata_q <= {16'h0000, tbl.rdata};
				end
				BUS_DONE: bus_q <= BUS_IDLE;
				default: bus_q <= BUS_IDLE;
			endcase
		end
	end

	// Writable registers take effect at the edge that ends the stall
	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			cfg_q <= CFG_RST; // RULE_07
			max_q <= MAX_SPEED_RST; // RULE_08
			min_q <= MIN_SPEED_RST; // RULE_09
			start_q <= START_VALUE_RST; // RULE_15
			rup_q <= RAMP_TIME_RST_MS; // RULE_14
			rdn_q <= RAMP_TIME_RST_MS; // RULE_14
			fmode_q <= FIX_DIRECT;
		end else if (wr_go && !is_table) begin
			case (AVS_ADDRESS_I)
				OFS_CONFIG: begin
					if (AVS_BYTEENABLE_I[0]) begin
						cfg_q <= AVS_WRITEDATA_I[CFG_W-1:0];
					end
				end
				OFS_MAX_SPEED: max_q <= lane_merge(max_q,
					AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				OFS_MIN_SPEED: min_q <= lane_merge(min_q,
					AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				OFS_START_VALUE: start_q <= lane_merge(start_q,
					AVS_WRITEDATA_I, AVS_BYTEENABLE_I); // RULE_15
				OFS_RAMP_UP: rup_q <= lane_merge(rup_q,
					AVS_WRITEDATA_I, AVS_BYTEENABLE_I); // RULE_14
				OFS_RAMP_DOWN: rdn_q <= lane_merge(rdn_q,
					AVS_WRITEDATA_I, AVS_BYTEENABLE_I); // RULE_14
				OFS_FIX_MODE: begin
					// Unknown mode codes are ignored to keep a legal mode
					if (AVS_BYTEENABLE_I[0] &&
						AVS_WRITEDATA_I[1:0] == FIX_BINARY) begin
						fmode_q <= FIX_BINARY;
					end else if (AVS_BYTEENABLE_I[0] &&
						AVS_WRITEDATA_I[1:0] == FIX_DIRECT) begin
						fmode_q <= FIX_DIRECT;
					end
				end
				default: ;
			endcase
		end
	end

	// Table writes store the whole low half-word
	assign tbl.we = wr_go && is_table;
	assign tbl.waddr = word_ofs[TBL_AW-1:0];
	assign tbl.wdata = AVS_WRITEDATA_I[15:0];

	// Fixed setpoint scanner shares the table read port with the bus
	logic [1:0] scan_q;
	logic scan_v_q;
	logic [TBL_AW-1:0] scan_idx_q, scan_addr;
	logic signed [SUM_W-1:0] sum_q;
	assign scan_addr = fmode_q == FIX_BINARY ? FIXED_SELECT_I
		: {2'b00, scan_q};
	assign tbl.raddr = bus_mem ? word_ofs[TBL_AW-1:0] : scan_addr;

	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			scan_q <= '0;
			scan_v_q <= 1'b0;
			scan_idx_q <= '0;
		end else begin
			scan_v_q <= !bus_mem;
			scan_idx_q <= scan_addr;
			if (!bus_mem) begin
				scan_q <= scan_q + 2'h1;
			end
		end
	end

	// Direct mode accumulates four words; binary mode takes one
	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			sum_q <= '0;
			fix_q <= '0;
		end else if (scan_v_q) begin
			if (fmode_q == FIX_BINARY) begin
				fix_q <= tbl.rdata; // RULE_12
			end else begin
				logic signed [SUM_W-1:0] s;
				s = scan_idx_q[1:0] == 2'h0 ? '0 : sum_q;
				if (FIXED_SELECT_I[scan_idx_q[1:0]]) begin
					s = s + spd_wide(tbl.rdata); // RULE_11
				end
				sum_q <= s;
				if (scan_idx_q[1:0] == 2'h3) begin
					fix_q <= spd_clamp(s, SPD_LO, SPD_HI); // RULE_11
				end
			end
		end
	end
	assign FIXED_SETPOINT_O = fix_q;
	assign FIXED_ACTIVE_O = FIXED_SELECT_I != 4'h0;

	// Millisecond tick for the ramp timebase
	logic [31:0] tick_cnt_q;
	logic tick;
	assign tick = tick_cnt_q == 32'(TICK_CYC - 1);
	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
		end
	end

	// Ramp stepping: one rpm per step, rate set by the ramp time
	logic up, down, ramp_on, computing, step;
	logic [31:0] acc_q, thresh;
	logic [3:0] round_q;
	assign up = POT_RAISE_COMMAND_I && !POT_LOWER_COMMAND_I; // RULE_16
	assign down = POT_LOWER_COMMAND_I && !POT_RAISE_COMMAND_I; // RULE_16
	assign computing = MOTOR_ON_I || cfg_q[CFG_ALWAYS]; // RULE_06
	assign ramp_on = !AUTO_MODE_SELECT_I // RULE_03
		|| cfg_q[CFG_AUTO_RAMP]; // RULE_02
	assign ramping = computing && (up || down);

	// Early steps need twice the time so a short tap moves very little
	always_comb begin
		thresh = {16'h0000, up ? rup_q : rdn_q};
		if (cfg_q[CFG_ROUND] && round_q < ROUND_STEPS) begin
			thresh = {15'h0000, thresh[15:0], 1'b0}; // RULE_04
		end
	end
	assign step = ramping && ramp_on && thresh != '0 && acc_q >= thresh;

	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I || !ramping) begin
			acc_q <= '0;
			round_q <= '0;
		end else if (step) begin
			acc_q <= acc_q - thresh;
			if (round_q < ROUND_STEPS) begin
				round_q <= round_q + 4'h1;
			end
		end else if (tick) begin
			acc_q <= acc_q + REF_SPEED_RPM;
		end
	end

	// Edge detectors for switch-on, switch-off and accept
	logic accept_q, boot_q;
	logic [SPD_W-1:0] saved_q;
	logic on_rise, off_fall, acc_rise;
	assign on_rise = MOTOR_ON_I && !motor_q;
	assign off_fall = !MOTOR_ON_I && motor_q;
	assign acc_rise = ACCEPT_SETTING_STROBE_I && !accept_q; // RULE_10

	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			motor_q <= 1'b0;
			accept_q <= 1'b0;
		end else begin
			motor_q <= MOTOR_ON_I;
			accept_q <= ACCEPT_SETTING_STROBE_I;
		end
	end

	// Stored value: caught at switch-off, reloaded from store after reset
	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			saved_q <= '0;
			boot_q <= 1'b0;
			NV_WRITE_O <= 1'b0;
			NV_DATA_O <= '0;
		end else begin
			boot_q <= 1'b1;
			NV_WRITE_O <= 1'b0;
			if (!boot_q && NV_VALID_I) begin
				saved_q <= NV_DATA_I; // RULE_05
			end else if (off_fall && cfg_q[CFG_STORE]) begin
				saved_q <= pot_q; // RULE_01
				if (cfg_q[CFG_NVSTORE]) begin
					NV_WRITE_O <= 1'b1; // RULE_05
					NV_DATA_O <= pot_q; // RULE_05
				end
			end
		end
	end

	// Next potentiometer value before the limits are applied
	logic signed [SUM_W-1:0] pot_d;
	always_comb begin
		pot_d = spd_wide(pot_q);
		if (on_rise) begin
			pot_d = cfg_q[CFG_STORE] ? spd_wide(saved_q) // RULE_01
				: spd_wide(start_q); // RULE_01
		end else if (acc_rise) begin
			pot_d = spd_wide(SETTING_VALUE_SOURCE_I); // RULE_10
		end else if (ramping && !ramp_on) begin
			pot_d = up ? spd_wide(max_q) : spd_wide(min_q); // RULE_02
		end else if (step) begin
			pot_d = up ? spd_wide(pot_q) + 18'sh00001 // RULE_13
				: spd_wide(pot_q) - 18'sh00001; // RULE_13
		end
	end

	// Limits are applied last, every cycle, so a limit change bites too
	always_ff @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			pot_q <= '0;
		end else begin
			pot_q <= spd_clamp(pot_d, spd_wide(min_q), // RULE_17 RULE_09
				spd_wide(max_q)); // RULE_08
		end
	end
	assign POT_OUTPUT_O = pot_q;
endmodule : ssrc_top

// *** ssrc_pkg.sv ***
// Package with register map, field layout, reset values and timing counts
package ssrc_pkg;
	localparam int SPD_W = 16;
	localparam int SUM_W = 18;
	localparam int TBL_N = 16;
	localparam int TBL_AW = 4;
	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_MAX_SPEED = 8'h04;
	localparam logic [7:0] OFS_MIN_SPEED = 8'h08;
	localparam logic [7:0] OFS_START_VALUE = 8'h0c;
	localparam logic [7:0] OFS_RAMP_UP = 8'h10;
	localparam logic [7:0] OFS_RAMP_DOWN = 8'h14;
	localparam logic [7:0] OFS_FIX_MODE = 8'h18;
	localparam logic [7:0] OFS_POT_OUT = 8'h1c;
	localparam logic [7:0] OFS_FIX_OUT = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_TABLE = 8'h40;
	localparam logic [1:0] TABLE_PAGE = 2'h1;
	// Configuration field bit positions
	localparam int CFG_STORE = 0;
	localparam int CFG_AUTO_RAMP = 1;
	localparam int CFG_ROUND = 2;
	localparam int CFG_NVSTORE = 3;
	localparam int CFG_ALWAYS = 4;
	localparam int CFG_W = 5;
	// Status bit positions
	localparam int ST_MOTOR_ON = 0;
	localparam int ST_FIX_ACTIVE = 1;
	localparam int ST_RAMPING = 2;
	// Reset values
	localparam logic [4:0] CFG_RST = 5'h06;
	localparam logic [15:0] MAX_SPEED_RST = 16'h0000;
	localparam logic [15:0] MIN_SPEED_RST = 16'h0000;
	localparam logic [15:0] START_VALUE_RST = 16'h0000;
	localparam logic [15:0] RAMP_TIME_RST_MS = 16'h2710;
	localparam logic signed [17:0] SPD_LO = 18'sh38000;
	localparam logic signed [17:0] SPD_HI = 18'sh07fff;
	// Ramp time is the time to ramp from zero to the reference speed
	localparam logic [31:0] REF_SPEED_RPM = 32'h0000_05dc;
	localparam logic [3:0] ROUND_STEPS = 4'h8;
	// Ramp timebase: one tick per millisecond
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	// Fixed setpoint selection modes
	typedef enum logic [1:0] {
		FIX_DIRECT = 2'b01,
		FIX_BINARY = 2'b10
	} ssrc_fix_mode_e;
	// Bus answer sequence
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_MEM = 2'b01,
		BUS_DONE = 2'b10
	} ssrc_bus_e;
endpackage : ssrc_pkg

// *** ssrc_mem_if.sv ***
// Interface between the setpoint logic and the fixed setpoint table
`timescale 1ns/1ps
interface ssrc_mem_if;
	import ssrc_pkg::*;
	logic we;
	logic [TBL_AW-1:0] waddr;
	logic [SPD_W-1:0] wdata;
	logic [TBL_AW-1:0] raddr;
	logic [SPD_W-1:0] rdata;
	modport ctrl (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : ssrc_mem_if

// *** ssrc_fixed_mem.sv ***
// Sixteen-word fixed setpoint table with registered read data
`timescale 1ns/1ps
module ssrc_fixed_mem (
	input wire logic clk_i, // Core clock
	input wire logic rstn_i, // Synchronous reset, active low
	ssrc_mem_if.mem mem // Table port
);
	import ssrc_pkg::*;
	logic [SPD_W-1:0] word_q [TBL_N];
	logic [SPD_W-1:0] rdata_q;

	// All setpoints start at zero speed
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < TBL_N; i++) begin
				word_q[i] <= '0;
			end
		end else if (mem.we) begin
			word_q[mem.waddr] <= mem.wdata;
		end
	end

	// Read data one cycle after the address
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= word_q[mem.raddr];
		end
	end

	assign mem.rdata = rdata_q;
endmodule : ssrc_fixed_mem

// *** ssrc_top_asserts.sv ***
// Checker of bus and potentiometer timing at the block ports
`timescale 1ns/1ps
module ssrc_top_asserts (
	input wire logic CORE_CLK_I, // Clock
	input wire logic RSTN_I, // Reset
	input wire logic AVS_READ_I, // Read
	input wire logic AVS_WRITE_I, // Write
	input wire logic AVS_WAITREQUEST_O, // Stall
	input wire logic MOTOR_ON_I, // Motor on
	input wire logic POT_RAISE_COMMAND_I, // Raise
	input wire logic POT_LOWER_COMMAND_I, // Lower
	input wire logic AUTO_MODE_SELECT_I, // Auto
	input wire logic ACCEPT_SETTING_STROBE_I, // Accept
	input wire logic [3:0] FIXED_SELECT_I, // Select
	input wire logic NV_WRITE_O, // Store
	input wire logic [15:0] NV_DATA_O, // Stored
	input wire logic [15:0] POT_OUTPUT_O, // Output
	input wire logic FIXED_ACTIVE_O // Active
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	// Three steady edges so that switch-on and accept loads are over
	sequence s_both;
		(POT_RAISE_COMMAND_I && POT_LOWER_COMMAND_I && MOTOR_ON_I &&
			!ACCEPT_SETTING_STROBE_I)[*3];
	endsequence : s_both
	sequence s_up;
		(POT_RAISE_COMMAND_I && !POT_LOWER_COMMAND_I && MOTOR_ON_I &&
			!AUTO_MODE_SELECT_I && !ACCEPT_SETTING_STROBE_I)[*3];
	endsequence : s_up
	a_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("answer held twice");
	a_wait_bound: assert property ((AVS_READ_I || AVS_WRITE_I) &&
		AVS_WAITREQUEST_O |-> ##[1:3] !AVS_WAITREQUEST_O)
		else $error("no answer");
	a_fix_active: assert property (
		FIXED_ACTIVE_O == (FIXED_SELECT_I != 4'h0)) else $error("active flag");
	a_nv_pulse: assert property (NV_WRITE_O |=> !NV_WRITE_O)
		else $error("store strobe long");
	a_nv_cause: assert property (NV_WRITE_O |-> !$past(MOTOR_ON_I))
		else $error("store while on");
	a_nv_data: assert property (
		NV_WRITE_O |-> NV_DATA_O == POT_OUTPUT_O) else $error("store value");
	a_both_hold: assert property (s_both |=> $stable(POT_OUTPUT_O))
		else $error("output moved");
	a_manual_step: assert property (s_up |=>
		$signed(POT_OUTPUT_O) - $signed($past(POT_OUTPUT_O)) inside {[0:1]})
		else $error("manual step");
endmodule : ssrc_top_asserts
bind ssrc_top ssrc_top_asserts i_ssrc_top_asserts (.CORE_CLK_I, .RSTN_I,
	.AVS_READ_I, .AVS_WRITE_I, .AVS_WAITREQUEST_O, .MOTOR_ON_I,
	.POT_RAISE_COMMAND_I, .POT_LOWER_COMMAND_I, .AUTO_MODE_SELECT_I,
	.ACCEPT_SETTING_STROBE_I, .FIXED_SELECT_I, .NV_WRITE_O, .NV_DATA_O,
	.POT_OUTPUT_O, .FIXED_ACTIVE_O);

// *** ssrc_cmd_src.sv ***
// Command source and value store facing the setpoint logic
`timescale 1ns/1ps
module ssrc_cmd_src (
	input wire logic clk_i, // Clock
	input wire logic [4:0] lvl_i, // Accept, auto, lower, raise, motor
	input wire logic nv_we_i, // Store strobe
	input wire logic [15:0] nv_d_i, // Value to store
	output logic [4:0] lvl_o, // Levels to the block
	output logic nv_valid_o, // Stored value present
	output logic [15:0] nv_q_o // Stored value
);
	initial begin
		lvl_o = 5'h00;
		nv_valid_o = 1'b0;
		nv_q_o = 16'h0;
	end
	// Levels change just after an edge and stand while asked
	always @(posedge clk_i) begin
		lvl_o <= lvl_i;
	end
	// Store outlives a reset of the block, as it would a loss of power
	always @(posedge clk_i) begin
		if (nv_we_i) begin
			nv_valid_o <= 1'b1;
			nv_q_o <= nv_d_i;
		end
	end
endmodule : ssrc_cmd_src

// *** ssrc_top_bench.sv ***
// Self-checking bench for the speed setpoint source
`timescale 1ns/1ps
module ssrc_top_bench;
	import ssrc_pkg::*;
	localparam logic [4:0] M = 5'h01, R = 5'h02, L = 5'h04;
	localparam logic [4:0] A = 5'h08, S = 5'h10;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic we = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, q;
	logic stall, nv_v, nv_we, fact;
	logic [4:0] lvl = 5'h00;
	logic [4:0] lv;
	logic [15:0] setv = 16'h0;
	logic [3:0] fsel = 4'h0;
	logic [15:0] nv_q, nv_d, pot, fix, g, ps, fs, nq;
	int fail_count = 0;
	int num_checks = 0;
	// Core clock
	always #2.5 clk = ~clk;
	ssrc_top #(.TICK_CYC(20)) i_ssrc_top (.CORE_CLK_I(clk), .RSTN_I(rst_n),
		.AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(we),
		.AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat),
		.AVS_WAITREQUEST_O(stall), .MOTOR_ON_I(lv[0]),
		.POT_RAISE_COMMAND_I(lv[1]), .POT_LOWER_COMMAND_I(lv[2]),
		.AUTO_MODE_SELECT_I(lv[3]), .ACCEPT_SETTING_STROBE_I(lv[4]),
		.SETTING_VALUE_SOURCE_I(setv), .FIXED_SELECT_I(fsel),
		.NV_VALID_I(nv_v), .NV_DATA_I(nv_q), .NV_WRITE_O(nv_we),
		.NV_DATA_O(nv_d), .POT_OUTPUT_O(pot), .FIXED_SETPOINT_O(fix),
		.FIXED_ACTIVE_O(fact));
	ssrc_cmd_src i_ssrc_cmd_src (.clk_i(clk), .lvl_i(lvl), .nv_we_i(nv_we),
		.nv_d_i(nv_d), .lvl_o(lv), .nv_valid_o(nv_v), .nv_q_o(nv_q));
	// Outputs sampled at the falling edge, clear of register updates
	always @(negedge clk) begin
		ps <= pot;
		fs <= fix;
		nq <= nv_q;
	end
	task automatic give_verdict();
		if (fail_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", n, x, s);
		end
	endtask : check
	// Request holds until stall is sampled low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		rd <= !w;
		we <= w;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				fail_count++;
				give_verdict();
			end
		end while (stall !== 1'b0);
		// Read data stand at the edge that ends the stall
		q = rdat;
		rd <= 1'b0;
		we <= 1'b0;
		// One idle edge so the next request is not a same-step redrive
		@(posedge clk);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rc(input string n, input logic [7:0] a,
		input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		check(n, q, x);
	endtask : rc
	task automatic drive(input logic [4:0] v, input int n);
		lvl <= v;
		repeat (n) @(posedge clk);
	endtask : drive
	task automatic ld(input logic [15:0] v, input logic [15:0] x);
		setv <= v;
		drive(M, 6);
		drive(M | S, 6);
		check("load", 32'(ps), 32'(x));
	endtask : ld
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : do_reset
	task automatic t_regs();
		check("reset out", 32'(ps), 32'h0);
		rc("config", OFS_CONFIG, 32'(CFG_RST));
		rc("max", OFS_MAX_SPEED, 32'h0);
		rc("min", OFS_MIN_SPEED, 32'h0);
		rc("start", OFS_START_VALUE, 32'h0);
		rc("up", OFS_RAMP_UP, 32'(RAMP_TIME_RST_MS));
		rc("down", OFS_RAMP_DOWN, 32'(RAMP_TIME_RST_MS));
		wr(OFS_CONFIG, 32'hffffffff);
		rc("config rw", OFS_CONFIG, 32'h1f);
		wr(OFS_CONFIG, 32'(CFG_RST));
		wr(8'h30, 32'h1234);
		rc("unmapped", 8'h30, 32'h0);
	endtask : t_regs
	// Every selection code in both modes; sums stay small and positive
	task automatic t_fixed();
		int e;
		for (int k = 0; k < 16; k++) begin
			wr(OFS_TABLE + 8'(4 * k), 32'(10 * k + 3));
		end
		rc("table", OFS_TABLE + 8'h08, 32'h17);
		for (int m = 1; m < 3; m++) begin
			wr(OFS_FIX_MODE, 32'(m));
			for (int s = 0; s < 16; s++) begin
				fsel <= 4'(s);
				repeat (12) @(posedge clk);
				e = (m == 2) ? 10 * s + 3 : 0;
				for (int b = 0; b < 4; b++) begin
					if (m == 1 && s[b]) begin
						e += 10 * b + 3;
					end
				end
				check("fixed", 32'(fs), 32'(e));
				check("active", 32'(fact), 32'(s != 0));
			end
		end
		wr(OFS_FIX_MODE, 32'h3);
		rc("mode", OFS_FIX_MODE, 32'h2);
	endtask : t_fixed
	task automatic t_clamp();
		wr(OFS_MAX_SPEED, 32'h64);
		wr(OFS_MIN_SPEED, 32'hffce);
		ld(16'h12c, 16'h64);
		ld(16'hff38, 16'hffce);
		ld(16'h1e, 16'h1e);
	endtask : t_clamp
	// 1500 ms ramp time gives one step per tick of 20 cycles
	task automatic t_ramp();
		wr(OFS_RAMP_UP, 32'h5dc);
		wr(OFS_RAMP_DOWN, 32'h5dc);
		rc("up set", OFS_RAMP_UP, 32'h5dc);
		wr(OFS_CONFIG, 32'h0);
		ld(16'h0, 16'h0);
		drive(M | R, 200);
		g = ps;
		check("manual", 32'(g > 16'h5 && g < 16'h10), 32'h1);
		wr(OFS_CONFIG, 32'h4);
		ld(16'h0, 16'h0);
		drive(M | R, 200);
		check("round", 32'($signed(ps) < $signed(g)), 32'h1);
		g = ps;
		drive(M | L, 200);
		check("lower", 32'($signed(ps) < $signed(g)), 32'h1);
	endtask : t_ramp
	task automatic t_auto();
		drive(M | A | R, 6);
		check("auto up", 32'(ps), 32'h64);
		drive(M | A | L, 6);
		check("auto down", 32'(ps), 32'hffce);
		drive(M | A | R | L, 8);
		check("both", 32'(ps), 32'hffce);
		rc("pot reg", OFS_POT_OUT, 32'h0000ffce);
		// Motor on, a fixed selection present, no net ramp command
		rc("status", OFS_STATUS, 32'h3);
		rc("fix reg", OFS_FIX_OUT, 32'h99);
		// Auto mode with ramping enabled must not jump to the maximum
		wr(OFS_CONFIG, 32'h2);
		drive(M | A | R, 6);
		check("auto ramp", 32'($signed(ps) < 16'sh0), 32'h1);
	endtask : t_auto
	task automatic t_store();
		wr(OFS_START_VALUE, 32'h28);
		drive(5'h0, 6);
		drive(M, 6);
		check("start", 32'(ps), 32'h28);
		wr(OFS_CONFIG, 32'h9);
		ld(16'h46, 16'h46);
		drive(5'h0, 6);
		check("stored", 32'(nq), 32'h46);
		drive(M, 6);
		check("restored", 32'(ps), 32'h46);
		drive(5'h0, 6);
		drive(R, 100);
		check("off hold", 32'(ps), 32'h46);
		wr(OFS_CONFIG, 32'h19);
		drive(R, 100);
		check("off ramp", 32'($signed(ps) > 16'sh46), 32'h1);
		drive(5'h0, 2);
		do_reset();
		wr(OFS_MAX_SPEED, 32'h64);
		wr(OFS_CONFIG, 32'h9);
		drive(M, 6);
		check("power loss", 32'(ps), 32'h46);
	endtask : t_store
	initial begin
		do_reset();
		t_regs();
		t_fixed();
		t_clamp();
		t_ramp();
		t_auto();
		t_store();
		give_verdict();
	end
endmodule : ssrc_top_bench
